// file: hw/mapc_pkg.sv
// Purpose: shared constants and carriers for the memory address path control
// Assumes: single processor clock, microinstruction strobes from the sequencer
// Notes: widths follow the processor word and map input
package mapc_pkg;
  localparam int ADDR_W = 15;
  localparam int KEY_W = 4;
  localparam int MAP_W = 19;
  localparam int WORD_W = 16;
  localparam int KEY_LSB = 12;
  localparam int KEY_MSB = 15;
  localparam int MAP_KEY_LSB = 15;
  localparam int SHIFT_IND_BIT = 2;
  localparam int VEC_W = 9;
  localparam logic [3:0] STD_INT_LOW = 4'h7;
  localparam logic [KEY_W-1:0] KEY_RESET = 4'h0;
  localparam int MIN_READ_STEPS = 2;

  typedef struct packed {
    logic start_read;
    logic start_write;
    logic wait_done;
    logic key_load;
    logic key_to_bus_b;
    logic mir_as_addr;
  } mapc_micro_t;

  typedef struct packed {
    logic [KEY_W-1:0] key;
    logic [ADDR_W:0] addr;
  } mapc_map_t;

  function automatic logic [MAP_W-1:0] mapc_form(input logic [KEY_W-1:0] key,
                                                 input logic [ADDR_W:0] addr,
                                                 input logic full64);
    logic [MAP_W-1:0] m;
    m = {key, addr[ADDR_W-1:0]};
    m[MAP_KEY_LSB] = key[0] | (full64 & addr[ADDR_W]);
    return m;
  endfunction : mapc_form
endpackage : mapc_pkg

// file: hw/mapc_key_map.sv
// Purpose: key register and 19-bit map input formation
// Assumes: dma_cycle is from the same clock
// Notes: bus b read during dma shows the io key
`timescale 1ns/1ps
`default_nettype none
module mapc_key_map (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic key_load,
  input wire logic [mapc_pkg::WORD_W-1:0] alu_out,
  input wire logic dma_cycle,
  input wire logic [mapc_pkg::KEY_W-1:0] io_key,
  input wire logic full64,
  input wire logic [mapc_pkg::ADDR_W:0] mem_addr,
  output logic [mapc_pkg::KEY_W-1:0] key_value,
  output logic [mapc_pkg::KEY_W-1:0] status_key,
  output logic [mapc_pkg::MAP_W-1:0] map_in
);
  import mapc_pkg::*;
  logic [KEY_W-1:0] key_reg;
  logic [KEY_W-1:0] key_next;
  wire [KEY_W-1:0] eff_key;

  // RULE1 key load path
  assign key_next = key_load ? alu_out[KEY_MSB:KEY_LSB] : key_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) key_reg <= KEY_RESET;
    else key_reg <= key_next;
  end
  // RULE5 io key substitution
  assign eff_key = dma_cycle ? io_key : key_reg;
  // RULE2 key on bus b
  assign status_key = eff_key;
  // RULE3 RULE4 map input forming
  assign map_in = mapc_form(eff_key, mem_addr, full64);
  assign key_value = key_reg;

  key_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    key_load |=> key_reg == $past(alu_out[KEY_MSB:KEY_LSB]))
    else $error("key register not loaded"); // RULE1
  map_sub_a: assert property (@(posedge clk) disable iff (!rst_n)
    dma_cycle |-> map_in[MAP_W-1:MAP_W-3] == io_key[KEY_W-1:1])
    else $error("io key not substituted"); // RULE5
  map_or_a: assert property (@(posedge clk) disable iff (!rst_n)
    (full64 && mem_addr[ADDR_W]) |-> map_in[MAP_KEY_LSB])
    else $error("bit 15 not ored"); // RULE4
endmodule : mapc_key_map
`default_nettype wire

// file: hw/mapc_protect.sv
// Purpose: write inhibit and interrupt generation under memory protection
// Assumes: violation decision comes from the protection option
// Notes: protection enable changes only by io instruction strobes
`timescale 1ns/1ps
`default_nettype none
module mapc_protect (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic io_prot_on,
  input wire logic io_prot_off,
  input wire logic write_req,
  input wire logic prot_reject,
  output logic prot_enabled,
  output logic write_ok,
  output logic prot_int,
  output logic io_int_req
);
  import mapc_pkg::*;
  logic en_reg;
  logic en_next;
  logic viol_reg;
  logic int_reg;
  wire viol;

  // RULE9 enable owned by io instructions only
  assign en_next = io_prot_on ? 1'b1 : (io_prot_off ? 1'b0 : en_reg);
  // RULE7 suppress rejected writes
  assign viol = en_reg & write_req & prot_reject;
  assign write_ok = write_req & ~viol;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      en_reg <= 1'b0;
      viol_reg <= 1'b0;
      int_reg <= 1'b0;
    end else begin
      en_reg <= en_next;
      viol_reg <= viol;
      int_reg <= viol & ~viol_reg;
    end
  end
  // RULE8 both interrupts on violation
  // violation stands for the whole write cycle, so only its first cycle interrupts
  assign prot_int = int_reg;
  assign io_int_req = int_reg;
  assign prot_enabled = en_reg;

  wr_inhibit_a: assert property (@(posedge clk) disable iff (!rst_n)
    (en_reg && prot_reject) |-> !write_ok)
    else $error("rejected write passed"); // RULE7
  viol_int_a: assert property (@(posedge clk) disable iff (!rst_n)
    (viol && !viol_reg) |=> prot_int && io_int_req)
    else $error("violation interrupt missing"); // RULE8
  int_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    prot_int |=> !prot_int)
    else $error("interrupt longer than one cycle"); // RULE8
endmodule : mapc_protect
`default_nettype wire

// file: hw/mapc_top.sv
// Purpose: processor memory address path control top
// Assumes: memory control answers with accept and done pulses
// Notes: protection, key and instruction buffer patch live here
// Behaviour
// RULE1: key register loads from alu 12-15
// RULE2: key readable on bus b status
// RULE3: key forms map bits 15-18
// RULE4: full 64k mode ors address bit 15
// RULE5: dma cycles use io key
// RULE6: microcode avoids dma during status read
// RULE7: protected rejected writes are suppressed
// RULE8: violation raises internal and io interrupt
// RULE9: protection off only via io instructions
// RULE10: compare pc with address, flag match
// RULE11: matching store overwrites instruction buffer
// RULE12: patch when non-memory step follows store
// RULE13: patch also on back-to-back memory steps
// RULE14: microcode follows stores with non-memory step
// RULE15: shift bit 2 forces sign test zero
// RULE16: direct memory register address uses new data
// RULE17: microcode avoids alu-routed register address
// RULE18: interrupt vector is field plus 0111; code appends io_int_low instead when io_int_std is low
// RULE19: dma transfers leave memory register alone
// RULE20: read data no earlier than second step
// RULE21: stall until new cycle accepted
// RULE22: microcode waits for done before use
`timescale 1ns/1ps
`default_nettype none
module mapc_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire mapc_pkg::mapc_micro_t micro,
  input wire logic step,
  input wire logic [mapc_pkg::WORD_W-1:0] alu_out,
  input wire logic [mapc_pkg::WORD_W-1:0] store_data,
  input wire logic [mapc_pkg::ADDR_W:0] mem_addr_src,
  input wire logic [mapc_pkg::ADDR_W:0] pc,
  input wire logic full64,
  input wire logic dma_cycle,
  input wire logic [mapc_pkg::KEY_W-1:0] io_key,
  input wire logic io_prot_on,
  input wire logic io_prot_off,
  input wire logic prot_reject,
  input wire logic mem_accept,
  input wire logic mem_done,
  input wire logic [mapc_pkg::WORD_W-1:0] mem_rdata,
  input wire logic ibuf_load,
  input wire logic [mapc_pkg::WORD_W-1:0] ibuf_fetch,
  input wire logic [3:0] shift_count,
  input wire logic int_take,
  input wire logic [4:0] interrupt_page_field,
  input wire logic [3:0] io_int_low,
  input wire logic io_int_std,
  output logic [mapc_pkg::MAP_W-1:0] map_in,
  output logic [mapc_pkg::KEY_W-1:0] status_key,
  output logic mem_write,
  output logic mem_start,
  output logic stall,
  output logic address_match_flag,
  output logic [mapc_pkg::WORD_W-1:0] ibuf,
  output logic [mapc_pkg::WORD_W-1:0] memory_input_reg,
  output logic input_sign_test,
  output logic [mapc_pkg::VEC_W-1:0] int_vector,
  output logic int_branch,
  output logic prot_int,
  output logic io_int_req
);
  import mapc_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b100
  } mapc_state_t;

  mapc_state_t state_reg;
  mapc_state_t state_next;
  logic [WORD_W-1:0] ibuf_reg;
  logic [WORD_W-1:0] ibuf_next;
  logic [WORD_W-1:0] mir_reg;
  logic [WORD_W-1:0] mir_next;
  logic [WORD_W-1:0] store_reg;
  logic [ADDR_W:0] addr_reg;
  logic [1:0] steps_reg;
  logic [1:0] steps_next;
  logic match_reg;
  logic [VEC_W-1:0] vec_reg;
  logic branch_reg;
  logic [KEY_W-1:0] key_value;
  logic write_ok;
  logic prot_enabled;

  wire busy;
  wire new_req;
  wire read_arrive;
  wire [ADDR_W:0] cur_addr;
  wire [ADDR_W:0] next_addr;
  wire store_patch;
  wire [3:0] vec_low;

  assign busy = (state_reg != ST_IDLE);
  assign new_req = micro.start_read | micro.start_write;
  // RULE21 interlock on back-to-back request
  assign stall = (busy & new_req & ~mem_accept) | (busy & micro.wait_done & ~mem_done);
  assign mem_start = new_req & (~busy | mem_accept);
  // RULE20 data no earlier than second step
  assign read_arrive = (state_reg == ST_READ) & mem_done & (steps_reg >= 2'(MIN_READ_STEPS));
  // RULE16 direct mir address takes fresh data
  assign next_addr = micro.mir_as_addr ?
                     (read_arrive ? mem_rdata[ADDR_W:0] : mir_reg[ADDR_W:0]) : mem_addr_src;
  assign cur_addr = busy ? addr_reg : next_addr;

  // RULE10 continuous pc comparison
  assign address_match_flag = (pc[ADDR_W-1:0] == cur_addr[ADDR_W-1:0]);
  // RULE11 RULE12 RULE13 patch on matching store
  assign store_patch = (state_reg == ST_WRITE) & match_reg & write_ok & mem_done;

  always_comb begin
    state_next = state_reg;
    steps_next = steps_reg;
    if (step && steps_reg != 2'h3) steps_next = steps_reg + 2'h1;
    case (state_reg)
      ST_IDLE: begin
        if (micro.start_read) state_next = ST_READ;
        else if (micro.start_write) state_next = ST_WRITE;
        if (new_req) steps_next = 2'h0;
      end
      ST_READ, ST_WRITE: begin
        if (mem_done && !(state_reg == ST_READ && steps_reg < 2'(MIN_READ_STEPS))) begin
          state_next = ST_IDLE;
          if (mem_start) begin
            state_next = micro.start_read ? ST_READ : ST_WRITE;
            steps_next = 2'h0;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // RULE19 only processor reads load mir
  assign mir_next = (read_arrive && !dma_cycle) ? mem_rdata : mir_reg;
  assign ibuf_next = store_patch ? store_reg : (ibuf_load ? ibuf_fetch : ibuf_reg);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      steps_reg <= 2'h0;
      mir_reg <= 16'h0000;
      ibuf_reg <= 16'h0000;
      store_reg <= 16'h0000;
      addr_reg <= 16'h0000;
      match_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      steps_reg <= steps_next;
      mir_reg <= mir_next;
      ibuf_reg <= ibuf_next;
      if (mem_start) begin
        addr_reg <= next_addr;
        store_reg <= store_data;
        match_reg <= address_match_flag;
      end
    end
  end

  // RULE18 interrupt vector forming
  assign vec_low = io_int_std ? STD_INT_LOW : io_int_low;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vec_reg <= 9'h000;
      branch_reg <= 1'b0;
    end else begin
      branch_reg <= int_take;
      if (int_take) vec_reg <= {interrupt_page_field, vec_low};
    end
  end

  // RULE15 indirection limit on sign test
  assign input_sign_test = mir_reg[WORD_W-1] & ~shift_count[SHIFT_IND_BIT];

  mapc_key_map u_key (
    .clk(clk),
    .rst_n(rst_n),
    .key_load(micro.key_load),
    .alu_out(alu_out),
    .dma_cycle(dma_cycle),
    .io_key(io_key),
    .full64(full64),
    .mem_addr(cur_addr),
    .key_value(key_value),
    .status_key(status_key),
    .map_in(map_in)
  );

  mapc_protect u_prot (
    .clk(clk),
    .rst_n(rst_n),
    .io_prot_on(io_prot_on),
    .io_prot_off(io_prot_off),
    .write_req(state_reg == ST_WRITE),
    .prot_reject(prot_reject),
    .prot_enabled(prot_enabled),
    .write_ok(write_ok),
    .prot_int(prot_int),
    .io_int_req(io_int_req)
  );

  assign mem_write = write_ok;
  assign ibuf = ibuf_reg;
  assign memory_input_reg = mir_reg;
  assign int_vector = vec_reg;
  assign int_branch = branch_reg;

  sequence store_hit_s;
    state_reg == ST_WRITE && match_reg && write_ok && mem_done;
  endsequence
  ibuf_patch_a: assert property (@(posedge clk) disable iff (!rst_n)
    store_hit_s |=> ibuf_reg == $past(store_reg))
    else $error("instruction buffer not patched"); // RULE11
  match_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pc[ADDR_W-1:0] == cur_addr[ADDR_W-1:0]) == address_match_flag)
    else $error("match flag wrong"); // RULE10
  sign_limit_a: assert property (@(posedge clk) disable iff (!rst_n)
    shift_count[SHIFT_IND_BIT] |-> !input_sign_test)
    else $error("sign test not forced"); // RULE15
  mir_dma_a: assert property (@(posedge clk) disable iff (!rst_n)
    dma_cycle |=> $stable(mir_reg))
    else $error("dma changed memory register"); // RULE19
  vec_form_a: assert property (@(posedge clk) disable iff (!rst_n)
    (int_take && io_int_std) |=> branch_reg && vec_reg[3:0] == 4'h7)
    else $error("interrupt vector wrong"); // RULE18
  stall_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (busy && new_req && !mem_accept) |-> stall && !mem_start)
    else $error("no interlock stall"); // RULE21
  read_early_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_READ && steps_reg < 2'h2) |-> !read_arrive)
    else $error("read data too early"); // RULE20
  mir_fresh_a: assert property (@(posedge clk) disable iff (!rst_n)
    (micro.mir_as_addr && read_arrive) |-> next_addr == mem_rdata[ADDR_W:0])
    else $error("stale memory register address"); // RULE16
endmodule : mapc_top
`default_nettype wire

// file: verification/mapc_mem_model.sv
// Purpose: memory control partner answering processor memory cycles
// Assumes: one cycle at a time, latency set by lat (3 or more)
// Notes: read data lines toggle outside the done cycle
`timescale 1ns/1ps
`default_nettype none
module mapc_mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mem_start,
  input wire logic stall,
  input wire logic [3:0] lat,
  input wire logic [15:0] rdata_val,
  output logic mem_accept,
  output logic mem_done,
  output logic [15:0] mem_rdata
);
  logic [4:0] cnt;
  always @(posedge clk) begin
    if (!rst_n) begin
      cnt <= 5'h0;
      mem_done <= 1'b0;
      mem_accept <= 1'b0;
      mem_rdata <= 16'h0;
    end else begin
      cnt <= mem_start ? {1'b0, lat} : (cnt != 5'h0 ? cnt - 5'h1 : 5'h0);
      mem_done <= !mem_start && cnt == 5'h2;
      mem_accept <= !mem_start && cnt == 5'h2 && stall;
      mem_rdata <= (!mem_start && cnt == 5'h2) ? rdata_val : ~mem_rdata;
    end
  end
endmodule : mapc_mem_model
`default_nettype wire

// file: verification/memory_address_path_control_test.sv
// Purpose: self-checking bench for the memory address path control
// Assumes: memory control answers through the partner model
// Notes: stimulus lands 1 ns after each rising edge
`timescale 1ns/1ps
`default_nettype none
module memory_address_path_control_test;
  import mapc_pkg::*;
  localparam mapc_micro_t RD = '{start_read: 1'b1, default: 1'b0};
  localparam mapc_micro_t WR = '{start_write: 1'b1, default: 1'b0};
  localparam mapc_micro_t KL = '{key_load: 1'b1, default: 1'b0};
  localparam mapc_micro_t BB = '{key_to_bus_b: 1'b1, default: 1'b0};
  logic clk = 0, rst_n = 0, step = 1, full64 = 0, dma_cycle = 0;
  logic io_prot_on = 0, io_prot_off = 0, prot_reject = 0, ibuf_load = 0;
  logic int_take = 0, io_int_std = 0, mem_accept, mem_done;
  mapc_micro_t micro = '0;
  logic [15:0] alu_out = 0, store_data = 0, mem_addr_src = 0, pc = 0, ibuf_fetch = 0;
  logic [15:0] rdata_val = 0, mem_rdata, ibuf, memory_input_reg;
  logic [3:0] io_key = 0, shift_count = 0, io_int_low = 0, lat = 4'h4, status_key;
  logic [4:0] interrupt_page_field = 0;
  logic [18:0] map_in;
  logic [8:0] int_vector;
  logic mem_write, mem_start, stall, address_match_flag, input_sign_test;
  logic int_branch, prot_int, io_int_req;
  int errors = 0, n_compared = 0, cycles = 0, pint = 0, iint = 0;

  mapc_top dut (.clk, .rst_n, .micro, .step, .alu_out, .store_data, .mem_addr_src, .pc,
    .full64, .dma_cycle, .io_key, .io_prot_on, .io_prot_off, .prot_reject, .mem_accept,
    .mem_done, .mem_rdata, .ibuf_load, .ibuf_fetch, .shift_count, .int_take,
    .interrupt_page_field, .io_int_low, .io_int_std, .map_in, .status_key, .mem_write,
    .mem_start, .stall, .address_match_flag, .ibuf, .memory_input_reg, .input_sign_test,
    .int_vector, .int_branch, .prot_int, .io_int_req);
  mapc_mem_model mem (.clk, .rst_n, .mem_start, .stall, .lat, .rdata_val, .mem_accept,
    .mem_done, .mem_rdata);

  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    pint <= pint + int'(prot_int === 1'b1);
    iint <= iint + int'(io_int_req === 1'b1);
    if (cycles == 3000) begin
      errors = errors + 1;
      wrap_up();
    end
  end

  task automatic cyc(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk(input logic [18:0] got, input logic [18:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // holds the request until the edge where it is not stalled
  task automatic op(input mapc_micro_t m);
    int n = 0;
    micro = m;
    #1;
    while (stall === 1'b1 && n < 50) begin
      cyc();
      n++;
    end
    cyc();
    micro = '0;
  endtask : op
  task automatic wait_done;
    int n = 0;
    while (mem_done !== 1'b1 && n < 40) begin
      cyc();
      n++;
    end
    chk(mem_done, 1);
    cyc();
  endtask : wait_done

  task automatic t_read;
    // address comes from the source, not via alu
    mem_addr_src = 16'h8123;
    rdata_val = 16'h8ABC;
    op(RD);
    chk(memory_input_reg, 0);
    wait_done();
    chk(memory_input_reg, 16'h8ABC);
    chk(input_sign_test, 1);
    shift_count = 4'h4;
    #1;
    chk(input_sign_test, 0);
    shift_count = 4'h0;
    rdata_val = 16'h1357;
    cyc();
    op(RD);
    micro = RD;
    #1;
    chk(stall, 1);
    op(RD);
    chk(memory_input_reg, 16'h1357);
    rdata_val = 16'h2468;
    wait_done();
    chk(memory_input_reg, 16'h2468);
    $display("test read done");
  endtask : t_read
  task automatic t_key;
    alu_out = 16'hA5FF;
    micro = KL;
    cyc();
    // status read, first with no dma active, then during a dma cycle
    micro = BB;
    #1;
    chk(status_key, 4'hA);
    chk(map_in, 19'h50123);
    full64 = 1;
    #1;
    chk(map_in, 19'h58123);
    full64 = 0;
    dma_cycle = 1;
    io_key = 4'h3;
    #1;
    chk(map_in, 19'h18123);
    chk(status_key, 4'h3);
    dma_cycle = 0;
    micro = '0;
    cyc();
    $display("test key done");
  endtask : t_key
  task automatic t_prot;
    io_prot_on = 1;
    cyc();
    io_prot_on = 0;
    prot_reject = 1;
    pc = 16'h7000;
    mem_addr_src = 16'h0100;
    pint = 0;
    iint = 0;
    op(WR);
    chk(mem_write, 0);
    wait_done();
    op(KL);
    op(WR);
    chk(mem_write, 0);
    wait_done();
    io_prot_off = 1;
    cyc();
    io_prot_off = 0;
    op(WR);
    chk(mem_write, 1);
    wait_done();
    cyc(2);
    chk(pint, 2);
    chk(iint, 2);
    prot_reject = 0;
    $display("test protect done");
  endtask : t_prot
  task automatic t_patch;
    ibuf_fetch = 16'h1111;
    ibuf_load = 1;
    cyc();
    ibuf_load = 0;
    pc = 16'h0200;
    mem_addr_src = 16'h0200;
    store_data = 16'hBEEF;
    micro = WR;
    #1;
    chk(address_match_flag, 1);
    op(WR);
    wait_done();
    chk(ibuf, 16'hBEEF);
    store_data = 16'hCAFE;
    op(WR);
    op(RD);
    wait_done();
    chk(ibuf, 16'hCAFE);
    pc = 16'h0201;
    store_data = 16'h5555;
    #1;
    chk(address_match_flag, 0);
    op(WR);
    wait_done();
    chk(ibuf, 16'hCAFE);
    $display("test patch done");
  endtask : t_patch
  task automatic t_int;
    interrupt_page_field = 5'h13;
    io_int_std = 1;
    io_int_low = 4'hA;
    int_take = 1;
    cyc();
    int_take = 0;
    chk(int_branch, 1);
    chk(int_vector, 9'h137);
    io_int_std = 0;
    int_take = 1;
    cyc();
    int_take = 0;
    chk(int_vector, 9'h13A);
    cyc();
    chk(int_branch, 0);
    $display("test interrupt done");
  endtask : t_int
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    cyc(5);
    rst_n = 1;
    t_read();
    t_key();
    t_prot();
    t_patch();
    t_int();
    wrap_up();
  end
endmodule : memory_address_path_control_test
`default_nettype wire
